// ===== etu_pkg.sv
`default_nettype none
package etu_pkg;
	localparam int TRACE_DEPTH = 32768;
	localparam int ENTRY_W = 96;
	localparam int TRIG_N = 5;
	localparam int BUS_W = 16;
	localparam int SLOT_N = 6;
	localparam int SLOT_IDX_W = 3;
	localparam int PART_W = 8;
	localparam int STAMP_W = 32;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PAD_W = ENTRY_W - STAMP_W - 2 * TRIG_N - 2 * BUS_W;

	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_OUT_MASK = 12'h008;
	localparam logic [11:0] OFS_IN_MASK = 12'h00C;
	localparam logic [11:0] OFS_TRACE_MASK = 12'h010;
	localparam logic [11:0] OFS_TARGET = 12'h014;
	localparam logic [11:0] OFS_SLOT_WR = 12'h018;
	localparam logic [11:0] OFS_SLOT_RD = 12'h01C;
	localparam logic [11:0] OFS_WR_PTR = 12'h020;
	localparam logic [11:0] OFS_TRACE_IDX = 12'h024;
	localparam logic [11:0] OFS_TRACE_W0 = 12'h028;
	localparam logic [11:0] OFS_TRACE_W1 = 12'h02C;
	localparam logic [11:0] OFS_TRACE_W2 = 12'h030;
	localparam logic [11:0] WORD_MASK = 12'hFFC;

	localparam int CTRL_RESUME_BIT = 0;
	localparam int CTRL_DL_START_BIT = 1;
	localparam int CTRL_DL_END_BIT = 2;
	localparam int ST_HALT_BIT = 0;
	localparam int ST_TRACE_BIT = 1;
	localparam int ST_DL_BUSY_BIT = 2;
	localparam int ST_DL_DONE_BIT = 3;
	localparam int ST_WRAPPED_BIT = 4;
	localparam int ST_ALLOWED_BIT = 5;
	localparam int SLOT_ID_LSB = 0;
	localparam int SLOT_VALID_BIT = 8;
	localparam int SLOT_IDX_LSB = 16;

	localparam logic [TRIG_N-1:0] MASK_RST = 5'h00;
	localparam logic [PART_W-1:0] TARGET_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam longint CLK_PERIOD_PS = 5000;
	localparam longint FLASH_HALF_MS = 250;
	localparam longint FLASH_HALF_CYC_L = FLASH_HALF_MS * 64'd1000000000 / CLK_PERIOD_PS;
	localparam int FLASH_HALF_CYC_DEF = int'(FLASH_HALF_CYC_L);

	typedef enum logic {DL_IDLE, DL_BUSY} etu_dl_t;
endpackage
`default_nettype wire

// ===== etu_top.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module etu_top #(
	parameter int DEPTH = etu_pkg::TRACE_DEPTH,
	parameter int FLASH_HALF_CYC = etu_pkg::FLASH_HALF_CYC_DEF
) (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [etu_pkg::ADDR_W-1:0]        s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [etu_pkg::DATA_W-1:0]        s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [etu_pkg::ADDR_W-1:0]        s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [etu_pkg::DATA_W-1:0]             s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic                              emulated_cpu_clock,
	input  wire logic                              instr_valid,
	input  wire logic [etu_pkg::BUS_W-1:0]         instr_addr,
	input  wire logic [etu_pkg::BUS_W-1:0]         data_bus,
	input  wire logic                              instr_bkpt,
	input  wire logic                              instr_trace_on,
	input  wire logic                              instr_trace_off,
	input  wire logic [etu_pkg::TRIG_N-1:0]        instr_trig,
	input  wire logic [etu_pkg::TRIG_N-1:0]        trig_in,
	input  wire logic                              power_cycle,
	output logic [etu_pkg::TRIG_N-1:0]             trig_out,
	output logic                                   halt,
	output logic                                   emu_enable,
	output logic                                   ready_led,
	output logic                                   la_clk,
	output logic [etu_pkg::BUS_W-1:0]              la_addr,
	output logic [etu_pkg::BUS_W-1:0]              la_data
);
	import etu_pkg::*;

	localparam int PW = $clog2(DEPTH);

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] nw, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[8*b +: 8] = nw[8*b +: 8];
		end
		return res;
	endfunction

	function automatic logic part_stored(input logic [SLOT_N-1:0] vld,
		input logic [SLOT_N*PART_W-1:0] ids, input logic [PART_W-1:0] part);
		logic hit;
		hit = 1'b0;
		for (int s = 0; s < SLOT_N; s++)
		begin
			if (vld[s] && ids[s*PART_W +: PART_W] == part)
				hit = 1'b1;
		end
		return hit;
	endfunction

	logic                      wr_acc_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]                bresp_r, rresp_r;
	logic [DATA_W-1:0]         rdata_r;
	logic [TRIG_N-1:0]         out_mask_r, in_mask_r, trace_mask_r, trig_q_r, trig_out_r;
	logic [PART_W-1:0]         target_r;
	logic                      cpu_clk_q_r, halt_r, trace_on_r, wrapped_r, dl_done_r;
	logic                      emu_en_r, led_r, la_clk_r;
	logic [BUS_W-1:0]          la_addr_r, la_data_r;
	logic [PW-1:0]             wr_ptr_r, trace_idx_r;
	logic [STAMP_W-1:0]        stamp_r;
	logic [31:0]               flash_cnt_r;
	etu_dl_t                   dl_r;
	logic [SLOT_N-1:0]         stg_vld_r, act_vld_r;
	logic [SLOT_N*PART_W-1:0]  stg_id_r, act_id_r;
	logic [ENTRY_W-1:0]        trace_mem [DEPTH];

	wire [11:0] waddr = s_axi_awaddr[11:0] & WORD_MASK;
	wire [11:0] raddr = s_axi_araddr[11:0] & WORD_MASK;
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~wr_acc_r & ~bvalid_r;
	wire rd_go = s_axi_arvalid & ~arready_r & ~rvalid_r;
	wire w_ctrl = wr_acc_r & (waddr == OFS_CTRL);
	wire w_status = wr_acc_r & (waddr == OFS_STATUS);
	wire w_omask = wr_acc_r & (waddr == OFS_OUT_MASK);
	wire w_imask = wr_acc_r & (waddr == OFS_IN_MASK);
	wire w_tmask = wr_acc_r & (waddr == OFS_TRACE_MASK);
	wire w_target = wr_acc_r & (waddr == OFS_TARGET);
	wire w_slot = wr_acc_r & (waddr == OFS_SLOT_WR);
	wire w_tidx = wr_acc_r & (waddr == OFS_TRACE_IDX);
	wire w_map = w_ctrl | w_status | w_omask | w_imask | w_tmask | w_target | w_slot | w_tidx;
	wire [DATA_W-1:0] wd = merge('0, s_axi_wdata, s_axi_wstrb);

	wire resume = w_ctrl & wd[CTRL_RESUME_BIT];
	wire dl_start = w_ctrl & wd[CTRL_DL_START_BIT];
	wire dl_end = w_ctrl & wd[CTRL_DL_END_BIT];
	wire done_clr = w_status & wd[ST_DL_DONE_BIT];
	wire [SLOT_IDX_W-1:0] slot_idx = wd[SLOT_IDX_LSB +: SLOT_IDX_W];
	wire slot_ok = w_slot & (dl_r == DL_BUSY) & (slot_idx < SLOT_IDX_W'(SLOT_N));

	wire allowed = part_stored(act_vld_r, act_id_r, target_r);
	wire cyc = emulated_cpu_clock & ~cpu_clk_q_r;
	wire trig_rise = |(trig_in & ~trig_q_r & in_mask_r);
	wire bkpt_hit = cyc & instr_valid & instr_bkpt & ~halt_r;
	wire exec = cyc & instr_valid & ~instr_bkpt & ~halt_r & allowed;
	wire rec = exec & (trace_on_r | instr_trace_on) & ~instr_trace_off;
	wire [TRIG_N-1:0] pulse = instr_trig & out_mask_r;
	wire [ENTRY_W-1:0] entry = {PAD_W'(0), stamp_r, pulse, trig_in & trace_mask_r,
		data_bus, instr_addr};
	wire [ENTRY_W-1:0] rd_entry = trace_mem[trace_idx_r];
	wire [DATA_W-1:0] status_w = DATA_W'({allowed, wrapped_r, dl_done_r,
		dl_r == DL_BUSY, trace_on_r, halt_r});

	wire r_map = (raddr == OFS_CTRL) | (raddr == OFS_STATUS) | (raddr == OFS_OUT_MASK)
		| (raddr == OFS_IN_MASK) | (raddr == OFS_TRACE_MASK) | (raddr == OFS_TARGET)
		| (raddr == OFS_SLOT_WR) | (raddr == OFS_SLOT_RD) | (raddr == OFS_WR_PTR)
		| (raddr == OFS_TRACE_IDX) | (raddr == OFS_TRACE_W0) | (raddr == OFS_TRACE_W1)
		| (raddr == OFS_TRACE_W2);
	wire [DATA_W-1:0] rd_val =
		(raddr == OFS_STATUS) ? status_w :
		(raddr == OFS_OUT_MASK) ? DATA_W'(out_mask_r) :
		(raddr == OFS_IN_MASK) ? DATA_W'(in_mask_r) :
		(raddr == OFS_TRACE_MASK) ? DATA_W'(trace_mask_r) :
		(raddr == OFS_TARGET) ? DATA_W'(target_r) :
		(raddr == OFS_SLOT_RD) ? {DATA_W'(stg_vld_r) << 8} | DATA_W'(act_vld_r) :
		(raddr == OFS_WR_PTR) ? DATA_W'(wr_ptr_r) :
		(raddr == OFS_TRACE_IDX) ? DATA_W'(trace_idx_r) :
		(raddr == OFS_TRACE_W0) ? rd_entry[31:0] :
		(raddr == OFS_TRACE_W1) ? rd_entry[63:32] :
		(raddr == OFS_TRACE_W2) ? rd_entry[95:64] : '0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_acc_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else
		begin
			wr_acc_r <= wr_go;
			if (wr_acc_r)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= w_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end
		else
		begin
			arready_r <= rd_go;
			if (arready_r)
			begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_val;
				rresp_r <= r_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				rvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_mask_r <= MASK_RST;
			in_mask_r <= MASK_RST;
			trace_mask_r <= MASK_RST;
			target_r <= TARGET_RST;
			trace_idx_r <= '0;
		end
		else
		begin
			if (w_omask)
				out_mask_r <= wd[TRIG_N-1:0];
			if (w_imask)
				in_mask_r <= wd[TRIG_N-1:0];
			if (w_tmask)
				trace_mask_r <= wd[TRIG_N-1:0];
			if (w_target)
				target_r <= wd[PART_W-1:0];
			if (w_tidx)
				trace_idx_r <= wd[PW-1:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_clk_q_r <= 1'b0;
			trig_q_r <= '0;
			halt_r <= 1'b0;
			trace_on_r <= 1'b0;
			stamp_r <= '0;
			trig_out_r <= '0;
		end
		else
		begin
			cpu_clk_q_r <= emulated_cpu_clock;
			trig_q_r <= trig_in;
			if (trig_rise | bkpt_hit)
				halt_r <= 1'b1;
			else if (resume)
				halt_r <= 1'b0;
			if (exec & instr_trace_on)
				trace_on_r <= 1'b1;
			else if (exec & instr_trace_off)
				trace_on_r <= 1'b0;
			if (cyc)
			begin
				stamp_r <= stamp_r + 1'b1;
				trig_out_r <= exec ? pulse : '0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr_r <= '0;
			wrapped_r <= 1'b0;
		end
		else if (rec)
		begin
			wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			if (wr_ptr_r == PW'(DEPTH - 1))
				wrapped_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (rec)
			trace_mem[wr_ptr_r] <= entry;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dl_r <= DL_IDLE;
			dl_done_r <= 1'b0;
			stg_vld_r <= '0;
			stg_id_r <= '0;
			act_vld_r <= '0;
			act_id_r <= '0;
		end
		else
		begin
			case (dl_r)
				DL_IDLE:
				begin
					if (dl_start)
						dl_r <= DL_BUSY;
				end
				DL_BUSY:
				begin
					if (dl_end)
						dl_r <= DL_IDLE;
				end
				default:
				begin
					dl_r <= DL_IDLE;
				end
			endcase
			if (dl_r == DL_BUSY && dl_end)
				dl_done_r <= 1'b1;
			else if (done_clr)
				dl_done_r <= 1'b0;
			if (slot_ok)
			begin
				stg_vld_r[slot_idx] <= wd[SLOT_VALID_BIT];
				stg_id_r[slot_idx*PART_W +: PART_W] <= wd[SLOT_ID_LSB +: PART_W];
			end
			if (power_cycle)
			begin
				act_vld_r <= stg_vld_r;
				act_id_r <= stg_id_r;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flash_cnt_r <= '0;
			led_r <= 1'b1;
			emu_en_r <= 1'b0;
			la_clk_r <= 1'b0;
			la_addr_r <= '0;
			la_data_r <= '0;
		end
		else
		begin
			if (dl_r == DL_BUSY)
			begin
				flash_cnt_r <= (flash_cnt_r == 32'(FLASH_HALF_CYC - 1)) ? '0 : flash_cnt_r + 1'b1;
				if (flash_cnt_r == 32'(FLASH_HALF_CYC - 1))
					led_r <= ~led_r;
			end
			else
			begin
				flash_cnt_r <= '0;
				led_r <= 1'b1;
			end
			emu_en_r <= allowed & ~halt_r;
			la_clk_r <= emulated_cpu_clock;
			la_addr_r <= instr_addr;
			la_data_r <= data_bus;
		end
	end

	assign s_axi_awready = wr_acc_r;
	assign s_axi_wready = wr_acc_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign trig_out = trig_out_r;
	assign halt = halt_r;
	assign emu_enable = emu_en_r;
	assign ready_led = led_r;
	assign la_clk = la_clk_r;
	assign la_addr = la_addr_r;
	assign la_data = la_data_r;
endmodule
`default_nettype wire

// ===== etu_chk.sv
`timescale 1ns/1ps
`default_nettype none
module etu_chk (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic                       s_axi_bvalid,
	input wire logic                       emulated_cpu_clock,
	input wire logic                       instr_valid,
	input wire logic                       instr_bkpt,
	input wire logic [etu_pkg::BUS_W-1:0]  instr_addr,
	input wire logic [etu_pkg::TRIG_N-1:0] instr_trig,
	input wire logic [etu_pkg::TRIG_N-1:0] trig_in,
	input wire logic [etu_pkg::TRIG_N-1:0] trig_out,
	input wire logic                       halt,
	input wire logic                       emu_enable,
	input wire logic                       la_clk,
	input wire logic [etu_pkg::BUS_W-1:0]  la_addr,
	input wire logic [etu_pkg::BUS_W-1:0]  data_bus,
	input wire logic [etu_pkg::BUS_W-1:0]  la_data
);
	import etu_pkg::*;
	logic              emu_q;
	logic [TRIG_N-1:0] trig_q;
	logic              cyc;
	logic              bk;
	logic [TRIG_N-1:0] rise;
	assign cyc = emulated_cpu_clock && !emu_q;
	assign bk = cyc && instr_valid && instr_bkpt;
	assign rise = trig_in & ~trig_q;
	always_ff @(posedge aclk)
	begin
		emu_q <= emulated_cpu_clock;
		trig_q <= trig_in;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_go;
		s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	endsequence
	sequence s_wr_ans;
		s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
	endsequence
	property p_wr_lat;
		s_wr_go |=> s_wr_ans;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer not on time");
	property p_la;
		$past(aresetn) |-> la_addr == $past(instr_addr) && la_data == $past(data_bus)
			&& la_clk == $past(emulated_cpu_clock);
	endproperty
	a_la: assert property (p_la) else $error("analyzer outputs wrong");
	property p_trig_hold;
		!cyc |=> $stable(trig_out);
	endproperty
	a_trig_hold: assert property (p_trig_hold) else $error("trigger moved mid cycle");
	property p_trig_idle;
		cyc && !instr_valid |=> trig_out == '0;
	endproperty
	a_trig_idle: assert property (p_trig_idle) else $error("trigger longer than a cycle");
	property p_trig_req;
		cyc |=> (trig_out & ~$past(instr_trig)) == '0;
	endproperty
	a_trig_req: assert property (p_trig_req) else $error("trigger not requested");
	property p_halt_cause;
		$rose(halt) |-> $past(bk) || $past(rise) != '0;
	endproperty
	a_halt_cause: assert property (p_halt_cause) else $error("halt without cause");
	property p_halt_stay;
		halt && !(s_axi_wvalid && s_axi_wready) |=> halt;
	endproperty
	a_halt_stay: assert property (p_halt_stay) else $error("halt dropped alone");
	property p_bkpt;
		bk && !halt && emu_enable |=> halt && trig_out == '0;
	endproperty
	a_bkpt: assert property (p_bkpt) else $error("breakpoint not halted");
	property p_no_exec;
		cyc |=> emu_enable || trig_out == '0;
	endproperty
	a_no_exec: assert property (p_no_exec) else $error("executed while stopped");
	property p_rst;
		disable iff (1'b0) !aresetn |=> trig_out == '0 && !halt && !emu_enable;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
`default_nettype wire

// ===== etu_target.sv
`timescale 1ns/1ps
`default_nettype none
module etu_target #(
	parameter int HALF = 2
) (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic [40:0]                op_in,
	output logic                           emulated_cpu_clock,
	output logic                           instr_valid,
	output logic                           instr_bkpt,
	output logic                           instr_trace_on,
	output logic                           instr_trace_off,
	output logic [etu_pkg::TRIG_N-1:0]     instr_trig,
	output logic [etu_pkg::BUS_W-1:0]      instr_addr,
	output logic [etu_pkg::BUS_W-1:0]      data_bus
);
	import etu_pkg::*;
	int          cnt_r;
	logic [40:0] op_r;
	assign {instr_valid, instr_bkpt, instr_trace_on, instr_trace_off, instr_trig, instr_addr,
		data_bus} = op_r;
	// The clock stays low in reset so the first edge seen is a clean rise.
	always_ff @(posedge aclk)
	begin
		op_r <= op_in;
		if (!aresetn)
		begin
			cnt_r <= 0;
			emulated_cpu_clock <= 1'b0;
		end
		else if (cnt_r == HALF - 1)
		begin
			cnt_r <= 0;
			emulated_cpu_clock <= !emulated_cpu_clock;
		end
		else
			cnt_r <= cnt_r + 1;
	end
endmodule
`default_nettype wire

// ===== etu_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module etu_top_bench;
	import etu_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        power_cycle = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [4:0]  trig_in = 5'h00;
	logic [40:0] op = 41'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        emulated_cpu_clock, instr_valid, instr_bkpt, instr_trace_on, instr_trace_off;
	logic        halt, emu_enable, ready_led, la_clk, lp;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic [4:0]  instr_trig, trig_out;
	logic [15:0] instr_addr, data_bus, la_addr, la_data;
	int          error_cnt = 0, n_compared = 0, i, k;
	etu_top #(.DEPTH(8), .FLASH_HALF_CYC(4)) u_etu_top (.*);
	etu_target #(.HALF(2)) u_etu_target (.aclk, .aresetn, .op_in(op), .emulated_cpu_clock,
		.instr_valid, .instr_bkpt, .instr_trace_on, .instr_trace_off, .instr_trig,
		.instr_addr, .data_bus);
	always #2.5 aclk = !aclk;
	task automatic stop_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task automatic tmo;
		chk("wait", 32'h1, 32'h0);
		stop_test;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		while (!s_axi_bvalid && n < 20);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (!s_axi_bvalid)
			tmo;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		while (!s_axi_rvalid && n < 20);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (!s_axi_rvalid)
			tmo;
		@(posedge aclk);
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rd(a);
		chk(nm, e, d & m);
	endtask
	task automatic ecyc;
		logic p;
		int   n;
		p = emulated_cpu_clock;
		for (n = 0; n < 20; n++)
		begin
			@(posedge aclk);
			if (emulated_cpu_clock && !p)
				break;
			p = emulated_cpu_clock;
		end
		if (n == 20)
			tmo;
	endtask
	task automatic exec(input logic [40:0] x);
		ecyc;
		op <= x;
		ecyc;
		op <= 41'h0;
		@(posedge aclk);
	endtask
	function automatic logic [40:0] mk(input logic b, input logic on, input logic off,
		input logic [4:0] t, input logic [15:0] a);
		return {1'b1, b, on, off, t, a, ~a};
	endfunction
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("ready_led", 32'h1, 32'(ready_led));
		rchk("status", OFS_STATUS, 32'h3F, 32'h0);
		for (i = 0; i < 3; i++)
			rchk("mask", OFS_OUT_MASK + 12'(4 * i), 32'h1F, 32'h0);
		rchk("wr_ptr", OFS_WR_PTR, 32'h7FFF, 32'h0);
		rd(12'h040);
		chk("unmapped", 32'(RESP_SLVERR), 32'(r));
		wr(12'h040, 32'h1F);
		chk("wr unmapped", 32'(RESP_SLVERR), 32'(r));
		s_axi_wstrb <= 4'h0;
		wr(OFS_OUT_MASK, 32'h1F);
		s_axi_wstrb <= 4'hF;
		chk("wr okay", 32'(RESP_OKAY), 32'(r));
		rchk("strobe", OFS_OUT_MASK, 32'h1F, 32'h0);
		wr(OFS_OUT_MASK, 32'h15);
		exec(mk(1'b0, 1'b0, 1'b0, 5'h1F, 16'h0010));
		chk("trig unstored", 32'h0, 32'(trig_out));
		wr(OFS_CTRL, 32'h2);
		rchk("busy", OFS_STATUS, 32'h4, 32'h4);
		k = 0;
		lp = ready_led;
		for (i = 0; i < 12; i++)
		begin
			@(posedge aclk);
			if (ready_led !== lp)
				k++;
			lp = ready_led;
		end
		chk("flash", 32'h3, 32'(k));
		wr(OFS_SLOT_WR, 32'h0000_015A);
		wr(OFS_CTRL, 32'h4);
		rchk("done", OFS_STATUS, 32'h2C, 32'h08);
		chk("led idle", 32'h1, 32'(ready_led));
		wr(OFS_STATUS, 32'h8);
		rchk("done clr", OFS_STATUS, 32'h8, 32'h0);
		wr(OFS_TARGET, 32'h5A);
		power_cycle <= 1'b1;
		@(posedge aclk);
		power_cycle <= 1'b0;
		@(posedge aclk);
		rchk("allowed", OFS_STATUS, 32'h20, 32'h20);
		chk("emu_enable", 32'h1, 32'(emu_enable));
		rchk("slots", OFS_SLOT_RD, 32'h3F3F, 32'h0101);
		wr(OFS_TRACE_MASK, 32'h03);
		for (i = 0; i < 5; i++)
		begin
			exec(mk(1'b0, 1'b0, 1'b0, 5'(1 << i), 16'h0020));
			chk("trig_out", 32'h15 & (32'h1 << i), 32'(trig_out));
		end
		ecyc;
		@(posedge aclk);
		chk("trig end", 32'h0, 32'(trig_out));
		rchk("untraced", OFS_WR_PTR, 32'h7FFF, 32'h0);
		trig_in <= 5'h1E;
		exec(mk(1'b0, 1'b1, 1'b0, 5'h03, 16'h0A00));
		exec(mk(1'b0, 1'b0, 1'b0, 5'h00, 16'h0A01));
		exec(mk(1'b0, 1'b0, 1'b1, 5'h00, 16'h0A02));
		exec(mk(1'b0, 1'b0, 1'b0, 5'h00, 16'h0A03));
		trig_in <= 5'h00;
		rchk("wr_ptr on", OFS_WR_PTR, 32'h7FFF, 32'h2);
		wr(OFS_TRACE_IDX, 32'h0);
		rchk("entry w0", OFS_TRACE_W0, 32'hFFFF_FFFF, 32'hF5FF_0A00);
		rchk("entry w1", OFS_TRACE_W1, 32'h3FF, 32'h022);
		rchk("entry pad", OFS_TRACE_W2, 32'hFFC0_0000, 32'h0);
		for (i = 0; i < 8; i++)
			exec(mk(1'b0, i == 0, i == 7, 5'h00, 16'h0B00 + 16'(i)));
		rchk("wr_ptr wrap", OFS_WR_PTR, 32'h7FFF, 32'h1);
		rchk("wrapped", OFS_STATUS, 32'h10, 32'h10);
		wr(OFS_TRACE_IDX, 32'h0);
		rchk("overwrite", OFS_TRACE_W0, 32'hFFFF, 32'h0B06);
		wr(OFS_IN_MASK, 32'h04);
		trig_in <= 5'h02;
		@(posedge aclk);
		trig_in <= 5'h00;
		repeat (2) @(posedge aclk);
		chk("halt masked", 32'h0, 32'(halt));
		trig_in <= 5'h04;
		@(posedge aclk);
		trig_in <= 5'h00;
		repeat (2) @(posedge aclk);
		chk("halt edge", 32'h1, 32'(halt));
		exec(mk(1'b0, 1'b0, 1'b0, 5'h1F, 16'h0C00));
		chk("halted trig", 32'h0, 32'(trig_out));
		wr(OFS_CTRL, 32'h1);
		chk("resume", 32'h0, 32'(halt));
		exec(mk(1'b1, 1'b0, 1'b0, 5'h01, 16'h0D00));
		chk("bkpt halt", 32'h1, 32'(halt));
		chk("bkpt trig", 32'h0, 32'(trig_out));
		stop_test;
	end
endmodule
bind etu_top etu_chk u_etu_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .emulated_cpu_clock, .instr_valid,
	.instr_bkpt, .instr_addr, .instr_trig, .trig_in, .trig_out, .halt, .emu_enable,
	.la_clk, .la_addr, .data_bus, .la_data);
`default_nettype wire
